/* pkg/ixc_pkg.sv */
package ixc_pkg;
   localparam logic [7:0] OP_SET_IDX     = 8'h37;
   localparam logic [7:0] OP_GET_IDX     = 8'h38;
   localparam logic [7:0] OP_ACC_TO_IDX  = 8'h39;
   localparam logic [7:0] OP_EXT_FIRST   = 8'h40;
   localparam logic [7:0] OP_EXT_LAST    = 8'h47;
   localparam logic [7:0] OP_MOVE_POS    = 8'h04;
   localparam logic [7:0] OP_REACH_REQ   = 8'h8a;
   localparam logic [7:0] ST_OK          = 8'h64;
   localparam logic [7:0] ST_REACHED     = 8'h80;
   localparam logic [7:0] ST_BAD_CMD     = 8'h02;
   localparam logic [7:0] REACH_ONCE     = 8'h00;
   localparam logic [7:0] REACH_ALWAYS   = 8'h01;
   localparam logic [7:0] REPLY_ADDR     = 8'h02;
   localparam logic [7:0] MODULE_ADDR    = 8'h01;
   localparam int         VAR_COUNT      = 256;
   localparam logic [31:0] IDX_MAX       = 32'h0000_00ff;
   localparam logic [31:0] ACC_RST       = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  kind;
      logic [7:0]  bank;
      logic [31:0] value;
   } ixc_cmd_t;

   typedef struct packed {
      logic [7:0]  host;
      logic [7:0]  module_addr;
      logic [7:0]  status;
      logic [7:0]  command;
      logic [31:0] value;
      logic [7:0]  checksum;
   } ixc_reply_t;

   function automatic logic [7:0] ixc_sum(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c, input logic [7:0] d,
                                          input logic [31:0] v);
      ixc_sum = a + b + c + d + v[31:24] + v[23:16] + v[15:8] + v[7:0];
   endfunction : ixc_sum
endpackage : ixc_pkg

/* src/ixc_var_array.sv */
module ixc_var_array
   import ixc_pkg::*;
#(
   parameter int DEPTH = VAR_COUNT
) (
   input  wire logic                     clk_sys,
   input  wire logic                     resetn,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [31:0]              wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [31:0]              rd_data
);
   logic [31:0] mem_r [DEPTH];

   assign rd_data = mem_r[rd_idx];

   // flip-flop storage keeps reset state defined for every user variable
   genvar g;
   for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            mem_r[g] <= 32'h0000_0000;
         end else if (wr_en && wr_idx == g) begin
            mem_r[g] <= wr_data;
         end
      end
   end
endmodule : ixc_var_array

/* src/ixc_cmd_core.sv */
module ixc_cmd_core
   import ixc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        cmd_valid,
   input  wire ixc_cmd_t    cmd,
   input  wire logic [31:0] index_reg,
   input  wire logic [31:0] ext_reply_value,
   input  wire logic        move_started,
   input  wire logic        move_done,
   output ixc_reply_t       reply,
   output logic             reply_valid,
   output logic [31:0]      accumulator,
   output logic             ext_strobe,
   output logic [2:0]       ext_select
);
   logic [31:0] acc_r;
   logic [31:0] acc_nxt;
   logic [31:0] var_rd;
   logic        idx_ok;
   logic        is_set;
   logic        is_get;
   logic        is_a2i;
   logic        is_ext;
   logic        is_reach;
   logic        is_move;
   logic        var_we;
   logic [31:0] var_wd;
   logic        arm_once_r;
   logic        arm_always_r;
   logic        tracking_r;
   logic [7:0]  mask_r;
   logic        reach_fire;
   ixc_reply_t  reply_r;
   ixc_reply_t  reply_nxt;
   logic        rv_r;
   logic        ext_r;
   logic [2:0]  sel_r;
   logic [7:0]  st_w;
   logic [31:0] val_w;

   assign is_set   = cmd_valid && cmd.opcode == OP_SET_IDX;
   assign is_get   = cmd_valid && cmd.opcode == OP_GET_IDX;
   assign is_a2i   = cmd_valid && cmd.opcode == OP_ACC_TO_IDX;
   assign is_ext   = cmd_valid && cmd.opcode >= OP_EXT_FIRST && cmd.opcode <= OP_EXT_LAST;
   assign is_reach = cmd_valid && cmd.opcode == OP_REACH_REQ;
   assign is_move  = move_started;

   assign idx_ok = !index_reg[31] && (index_reg <= IDX_MAX);

   assign var_we = (is_set || is_a2i) && idx_ok;
   assign var_wd = is_set ? cmd.value : acc_r;

   assign acc_nxt = (is_get && idx_ok) ? var_rd : acc_r;

   ixc_var_array #(.DEPTH(VAR_COUNT)) i_ixc_var_array (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .wr_en   (var_we),
      .wr_idx  (index_reg[7:0]),
      .wr_data (var_wd),
      .rd_idx  (index_reg[7:0]),
      .rd_data (var_rd)
   );

   // reached event only for a tracked move
   assign reach_fire = move_done && tracking_r;

   assign st_w  = reach_fire ? ST_REACHED : (is_set || is_get || is_a2i || is_ext || is_reach)
                  ? ST_OK : ST_BAD_CMD;
   assign val_w = reach_fire ? {24'h000000, mask_r}
                : is_reach ? {24'h000000, cmd.value[7:0]}
                : is_ext ? ext_reply_value
                : is_get ? acc_nxt : 32'h0000_0000;

   always_comb begin
      reply_nxt.host        = REPLY_ADDR;
      reply_nxt.module_addr = MODULE_ADDR;
      reply_nxt.status      = st_w;
      reply_nxt.command     = reach_fire ? OP_REACH_REQ : cmd.opcode;
      reply_nxt.value       = val_w;
      reply_nxt.checksum    = ixc_sum(REPLY_ADDR, MODULE_ADDR, st_w, reply_nxt.command, val_w);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc_r <= ACC_RST;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         arm_once_r   <= 1'b0;
         arm_always_r <= 1'b0;
         mask_r       <= 8'h00;
      end else if (is_reach) begin
         arm_once_r   <= cmd.kind == REACH_ONCE;
         arm_always_r <= cmd.kind == REACH_ALWAYS;
         mask_r       <= cmd.value[7:0];
      end else if (is_move) begin
         arm_once_r   <= 1'b0;
      end
   end

   // a new move outranks the done of the previous one in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tracking_r <= 1'b0;
      end else if (is_move) begin
         tracking_r <= arm_once_r || arm_always_r;
      end else if (move_done) begin
         tracking_r <= 1'b0;
      end
   end

   // reached reply takes the slot; a command in that cycle gets no reply of its own
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reply_r <= '0;
         rv_r    <= 1'b0;
         ext_r   <= 1'b0;
         sel_r   <= 3'h0;
      end else begin
         rv_r    <= cmd_valid || reach_fire;
         ext_r   <= is_ext;
         sel_r   <= cmd.opcode[2:0];
         if (cmd_valid || reach_fire) begin
            reply_r <= reply_nxt;
         end
      end
   end

   assign reply       = reply_r;
   assign reply_valid = rv_r;
   assign accumulator = acc_r;
   assign ext_strobe  = ext_r;
   assign ext_select  = sel_r;

   AST_GET_LOADS: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_get && idx_ok && !reach_fire |=> accumulator == $past(var_rd))
      else $error("accumulator not loaded from variable");
   AST_BAD_IDX: assert property (@(posedge clk_sys) disable iff (!resetn)
      cmd_valid && !idx_ok |=> accumulator == $past(accumulator))
      else $error("invalid index changed accumulator");
   AST_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
      !idx_ok |-> !var_we)
      else $error("write with invalid index");
   AST_SET_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_set && idx_ok |-> var_we && var_wd == cmd.value)
      else $error("set did not write immediate");
   AST_A2I_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_a2i && idx_ok |-> var_we && var_wd == accumulator)
      else $error("accumulator not written");
   AST_EXT_OK: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_ext && !reach_fire |=> reply_valid && reply.status == ST_OK && ext_strobe)
      else $error("extension reply wrong");
   AST_REACH_IMM: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_reach && !reach_fire |=> reply.status == ST_OK && reply.command == OP_REACH_REQ
      && reply.value[31:8] == 24'h000000)
      else $error("immediate reach reply wrong");
   AST_REACHED: assert property (@(posedge clk_sys) disable iff (!resetn)
      reach_fire |=> reply_valid && reply.status == ST_REACHED
      && reply.command == OP_REACH_REQ)
      else $error("reached reply wrong");
   AST_ONCE: assert property (@(posedge clk_sys) disable iff (!resetn)
      is_move && !is_reach |=> !arm_once_r)
      else $error("one-shot not cleared");

   sequence s_armed_move;
      (arm_once_r || arm_always_r) && is_move;
   endsequence : s_armed_move

   sequence s_still_moving;
      !move_done && !is_move;
   endsequence : s_still_moving

   AST_TRACKS: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_armed_move |=> tracking_r)
      else $error("armed move not tracked");
   AST_ALWAYS: assert property (@(posedge clk_sys) disable iff (!resetn)
      arm_always_r && is_move ##1 s_still_moving |-> tracking_r ##1 tracking_r)
      else $error("persistent arming lost");
   AST_ANSWERED: assert property (@(posedge clk_sys) disable iff (!resetn)
      cmd_valid |=> reply_valid)
      else $error("command not answered");
   AST_IDX_STATUS: assert property (@(posedge clk_sys) disable iff (!resetn)
      (is_set || is_get || is_a2i) && !reach_fire |=> reply.status == ST_OK
      && reply.command == $past(cmd.opcode))
      else $error("indexed command reply wrong");
   AST_SUM: assert property (@(posedge clk_sys) disable iff (!resetn)
      reply_valid |-> reply.checksum == 8'(reply.host + reply.module_addr + reply.status
      + reply.command + reply.value[31:24] + reply.value[23:16] + reply.value[15:8]
      + reply.value[7:0]))
      else $error("bad checksum");
endmodule : ixc_cmd_core

/* verification/ixc_host_model.sv */
module ixc_host_model
   import ixc_pkg::*;
(
   input  wire logic        clk_sys,
   output ixc_cmd_t         cmd,
   output logic             cmd_valid,
   output logic [31:0]      index_reg,
   output logic [31:0]      ext_reply_value,
   output logic             move_started,
   output logic             move_done
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd             = '0;
      cmd_valid       = 1'b0;
      index_reg       = 32'h0000_0000;
      ext_reply_value = 32'h0000_0000;
      move_started    = 1'b0;
      move_done       = 1'b0;
   end

   task automatic set_lv(input logic [31:0] idx, input logic [31:0] ev);
      @(negedge clk_sys);
      index_reg       <= idx;
      ext_reply_value <= ev;
   endtask : set_lv

   task automatic send(input logic [7:0] op, input logic [7:0] kind, input logic [31:0] val);
      @(negedge clk_sys);
      cmd       <= '{op, kind, 8'h00, val};
      cmd_valid <= 1'b1;
      @(negedge clk_sys);
      cmd_valid <= 1'b0;
      // stale fields inverted so nothing is read from a released bus
      cmd       <= ~cmd;
   endtask : send

   // gap sets a prompt or a slow motor
   task automatic move(input int gap);
      @(negedge clk_sys);
      move_started <= 1'b1;
      @(negedge clk_sys);
      move_started <= 1'b0;
      repeat (gap) @(negedge clk_sys);
      move_done <= 1'b1;
      @(negedge clk_sys);
      move_done <= 1'b0;
   endtask : move
endmodule : ixc_host_model

/* verification/test_indexed_var_and_reach_event_cmds.sv */
module test_indexed_var_and_reach_event_cmds
   import ixc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, resetn, cmd_valid, move_started, move_done, reply_valid, ext_strobe;
   ixc_cmd_t    cmd;
   ixc_reply_t  reply;
   logic [31:0] index_reg, ext_reply_value, accumulator, acc_keep;
   logic [2:0]  ext_select;
   int          fails = 0;
   int          comparisons = 0;

   ixc_host_model i_ixc_host_model (.clk_sys(clk_sys), .cmd(cmd), .cmd_valid(cmd_valid),
      .index_reg(index_reg), .ext_reply_value(ext_reply_value),
      .move_started(move_started), .move_done(move_done));
   ixc_cmd_core i_ixc_cmd_core (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd(cmd), .index_reg(index_reg), .ext_reply_value(ext_reply_value),
      .move_started(move_started), .move_done(move_done), .reply(reply),
      .reply_valid(reply_valid), .accumulator(accumulator), .ext_strobe(ext_strobe),
      .ext_select(ext_select));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // checksum worked out here, independent of the package helper
   task automatic wait_reply(input logic [7:0] st, input logic [7:0] cm, input logic [31:0] v);
      int         n;
      logic [7:0] s;
      n = 0;
      s = 8'h03 + st + cm + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      while (reply_valid !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (reply_valid !== 1'b1) begin
         fails++;
         end_sim();
      end
      chk(reply, {8'h02, 8'h01, st, cm, v, s});
   endtask : wait_reply

   task automatic get_at(input logic [31:0] idx, input logic [31:0] exp);
      i_ixc_host_model.set_lv(idx, 32'h0);
      i_ixc_host_model.send(OP_GET_IDX, 8'h5a, 32'h1234_5678);
      wait_reply(ST_OK, OP_GET_IDX, exp);
      chk(accumulator, exp);
   endtask : get_at

   task automatic t_set_get();
      get_at(32'd7, 32'h0);
      i_ixc_host_model.set_lv(32'd3, 32'h0);
      i_ixc_host_model.send(OP_SET_IDX, 8'h00, 32'h0000_0003);
      wait_reply(ST_OK, OP_SET_IDX, 32'h0);
      i_ixc_host_model.set_lv(32'd255, 32'h0);
      i_ixc_host_model.send(OP_SET_IDX, 8'h00, 32'hdead_beef);
      wait_reply(ST_OK, OP_SET_IDX, 32'h0);
      get_at(32'd3, 32'h3);
      get_at(32'd255, 32'hdead_beef);
   endtask : t_set_get

   task automatic t_acc_to_var();
      i_ixc_host_model.set_lv(32'd0, 32'h0);
      i_ixc_host_model.send(OP_ACC_TO_IDX, 8'h00, 32'h0);
      wait_reply(ST_OK, OP_ACC_TO_IDX, 32'h0);
      get_at(32'd3, 32'h3);
      get_at(32'd0, 32'hdead_beef);
   endtask : t_acc_to_var

   // low bits of both bad indices alias entries 0 and 255; the accumulator is made to
   // differ from them first, so an aliased get or accumulator write would show
   task automatic t_bad_idx();
      logic [31:0] bad [2] = '{32'd256, 32'hffff_ffff};
      get_at(32'd3, 32'h3);
      foreach (bad[i]) begin
         acc_keep = accumulator;
         i_ixc_host_model.set_lv(bad[i], 32'h0);
         i_ixc_host_model.send(OP_SET_IDX, 8'h00, 32'h0000_0055);
         wait_reply(ST_OK, OP_SET_IDX, 32'h0);
         i_ixc_host_model.send(OP_ACC_TO_IDX, 8'h00, 32'h0);
         wait_reply(ST_OK, OP_ACC_TO_IDX, 32'h0);
         get_at(bad[i], acc_keep);
      end
      get_at(32'd255, 32'hdead_beef);
      get_at(32'd0, 32'hdead_beef);
   endtask : t_bad_idx

   task automatic t_ext();
      for (int i = 0; i < 8; i++) begin
         i_ixc_host_model.set_lv(32'd0, 32'hc0de_0000 + i);
         i_ixc_host_model.send(OP_EXT_FIRST + i[7:0], i[7:0], 32'h0);
         wait_reply(ST_OK, OP_EXT_FIRST + i[7:0], 32'hc0de_0000 + i);
         chk({ext_strobe, ext_select}, {1'b1, i[2:0]});
      end
      i_ixc_host_model.send(OP_EXT_LAST + 8'h01, 8'h00, 32'h0);
      wait_reply(ST_BAD_CMD, OP_EXT_LAST + 8'h01, 32'h0);
   endtask : t_ext

   task automatic t_reach(input logic [7:0] kind);
      i_ixc_host_model.send(OP_REACH_REQ, kind, 32'h0000_0001);
      wait_reply(ST_OK, OP_REACH_REQ, 32'h1);
      for (int m = 0; m < 3; m++) begin
         i_ixc_host_model.move(2 + m * 15);
         if (kind == REACH_ALWAYS || m == 0) wait_reply(ST_REACHED, OP_REACH_REQ, 32'h1);
         else chk(reply_valid, 1'b0);
      end
   endtask : t_reach

   initial begin
      resetn = 1'b0;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      resetn = 1'b1;
      chk(accumulator, ACC_RST);
      chk(reply_valid, 1'b0);
      t_set_get();
      t_acc_to_var();
      t_bad_idx();
      t_ext();
      t_reach(REACH_ONCE);
      t_reach(REACH_ALWAYS);
      end_sim();
   end
endmodule : test_indexed_var_and_reach_event_cmds
